// [design/trigger_unit_map.vh]
// trigger_unit_map.vh: register offsets, field positions, reset values, state codes
// assumes inclusion by bare name from design files; definitions only
`ifndef TRIGGER_UNIT_MAP_VH
`define TRIGGER_UNIT_MAP_VH

// register byte offsets
`define REG_CONFIG        4'h0
`define REG_COMMAND       4'h4
`define REG_STATUS        4'h8
`define REG_EVENT_COUNT   4'hC

// config fields
`define CFG_TRIG_MODE_BIT     0
`define CFG_EDGE_SELECT_BIT   1
`define CFG_UART_STREAM_BIT   2
`define CFG_BAUD_LSB          4
`define CFG_BAUD_MSB          7
`define CFG_RESET             8'h00

// command fields (write-only pulses)
`define CMD_ARM_BIT           0
`define CMD_SOFT_START_BIT    1
`define CMD_STOP_BIT          2
`define CMD_READ_CONFIG_BIT   3
`define CMD_DISARM_BIT        4

// status fields
`define STS_ARMED_BIT         0
`define STS_RUNNING_BIT       1
`define STS_MODE_OK_BIT       2
`define STS_SNAPSHOT_BIT      3

// states
`define ST_IDLE               2'h0
`define ST_ARMED              2'h1
`define ST_RUN                2'h2

`endif

// [design/edge_sync.v]
// edge_sync.v: two-flop synchroniser with edge detector for one pin
// assumes pin_in is asynchronous to clk; edge_sel picks the edge to report
`default_nettype none
module edge_sync
(
  input  wire clk,
  input  wire rst_n,
  input  wire pin_in,
  input  wire edge_sel,
  output wire level,
  output wire edge_hit
);
  reg meta_q;
  reg sync_q;
  reg prev_q;

  // meta_q feeds only sync_q; edge logic looks at sync_q and prev_q
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end
    else
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  // 1 selects rising, 0 falling
  assign edge_hit = edge_sel ? (sync_q & ~prev_q) : (~sync_q & prev_q);
endmodule // edge_sync
`default_nettype wire

// [design/external_trigger_unit.v]
// external_trigger_unit.v: hardware trigger input and output around the serial pins
// assumes one 10 MHz clock, asynchronous rx pin, plain strobe register port
`include "trigger_unit_map.vh"
`default_nettype none
module external_trigger_unit
(
  input  wire        clk,
  input  wire        rst_n,
  input  wire [3:0]  addr,
  input  wire [7:0]  wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [7:0]  rdata,
  input  wire        uart_rx_pin,
  output reg         uart_tx_pin,
  input  wire        uart_tx_data,
  output wire        uart_rx_data,
  output wire        uart_path_en,
  output wire        usb_only,
  input  wire        acq_done,
  output wire        acq_start,
  output wire        acq_running,
  output reg  [7:0]  stored_config,
  output reg         stored_config_valid
);
  reg  [7:0] config_q;
  reg  [1:0] state_q;
  reg  [1:0] state_d;
  reg  [7:0] count_q;
  reg        start_q;
  wire       trig_mode;
  wire       edge_sel;
  wire       rx_level;
  wire       rx_edge;
  wire       wr_cfg;
  wire       wr_cmd;
  wire       cmd_arm;
  wire       cmd_soft;
  wire       cmd_stop;
  wire       cmd_disarm;
  wire       cmd_read;

  // command bits are decoded straight from the write strobe; nothing is
  // latched, so a command word acts exactly once and cannot be replayed
  // by a later unrelated write
  // several command bits in one word are legal; the state machine below
  // gives stop and disarm precedence over a start in the armed state; from idle the start wins
  // the config register is plain flops here; keeping it across power loss
  // is the job of the storage that loads it at boot
  assign trig_mode = config_q[`CFG_TRIG_MODE_BIT];
  assign edge_sel  = config_q[`CFG_EDGE_SELECT_BIT];
  assign wr_cfg    = wr && (addr == `REG_CONFIG);
  assign wr_cmd    = wr && (addr == `REG_COMMAND);
  assign cmd_arm    = wr_cmd && wdata[`CMD_ARM_BIT];
  assign cmd_soft   = wr_cmd && wdata[`CMD_SOFT_START_BIT];
  assign cmd_stop   = wr_cmd && wdata[`CMD_STOP_BIT];
  assign cmd_read   = wr_cmd && wdata[`CMD_READ_CONFIG_BIT];
  assign cmd_disarm = wr_cmd && wdata[`CMD_DISARM_BIT];

  // rx pin passes two flops before the edge detector
  edge_sync u_rx_sync
  (
    .clk      (clk),
    .rst_n    (rst_n),
    .pin_in   (uart_rx_pin),
    .edge_sel (edge_sel),
    .level    (rx_level),
    .edge_hit (rx_edge)
  );

  // serial path gets the pins only outside trigger mode
  assign uart_rx_data = trig_mode ? 1'b1 : rx_level;
  assign uart_path_en = ~trig_mode;
  assign usb_only     = trig_mode;

  // stored settings: mode, edge, streaming enable, baud code
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      config_q <= `CFG_RESET;
    else if (wr_cfg)
      config_q <= wdata;
  end

  // acquisition state; stop beats a same-cycle start when armed or running, not in idle
  // idle:  waits for arm or a software start, only in trigger mode
  // armed: waits for the selected edge of the synchronised rx pin;
  //        edges seen while idle or running are simply dropped
  // run:   ends on stop, on done from the sampling engine, or when
  //        software leaves trigger mode under a running capture
  // leaving trigger mode from any state returns to idle so that the
  // serial path gets clean pins back
  // unused code 3 falls back to idle rather than locking up
  always @*
  begin
    state_d = state_q;
    case (state_q)
      `ST_IDLE:
      begin
        if (trig_mode && cmd_soft)
          state_d = `ST_RUN;
        else if (trig_mode && cmd_arm)
          state_d = `ST_ARMED;
      end
      `ST_ARMED:
      begin
        if (!trig_mode || cmd_disarm || cmd_stop)
          state_d = `ST_IDLE;
        else if (rx_edge || cmd_soft)
          state_d = `ST_RUN;
      end
      `ST_RUN:
      begin
        if (cmd_stop || acq_done || !trig_mode)
          state_d = `ST_IDLE;
      end
      default:
        state_d = `ST_IDLE;
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= `ST_IDLE;
      start_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      // one pulse on entry to run, two flops plus one after the pin edge
      start_q <= (state_d == `ST_RUN) && (state_q != `ST_RUN);
    end
  end

  assign acq_start   = start_q;
  assign acq_running = (state_q == `ST_RUN);

  // tx pin: idle is the opposite of the active level set by the edge setting
  // the pin follows state_d, so it swings on the same edge as the state
  // register rather than one cycle behind it; this keeps the output pulse
  // aligned with the running flag seen by software
  // outside trigger mode the uart owns the pin and it carries serial data
  // a far receiver may leave the line open; nothing here reads it back
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      uart_tx_pin <= 1'b1;
    else if (!trig_mode)
      uart_tx_pin <= uart_tx_data;
    else if (state_d == `ST_RUN)
      uart_tx_pin <= edge_sel;
    else
      uart_tx_pin <= ~edge_sel;
  end

  // count of started acquisitions, for software visibility
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_q <= 8'h00;
    else if (start_q)
      count_q <= count_q + 8'h01;
  end

  // readback of stored settings on command
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stored_config       <= 8'h00;
      stored_config_valid <= 1'b0;
    end
    else
    begin
      stored_config_valid <= cmd_read;
      if (cmd_read)
        stored_config <= config_q;
    end
  end

  // read data one cycle after the strobe, zero otherwise
  // status: b0 armed, b1 running, b2 mode ready (trigger mode with serial
  // rate and streaming both cleared), b3 snapshot valid or matching
  // the command register is write-only and reads back as zero
  // the event count wraps silently at 8 bits; software must poll it often
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else if (!rd)
      rdata <= 8'h00;
    else if (addr == `REG_CONFIG)
      rdata <= config_q;
    else if (addr == `REG_STATUS)
      rdata <= {4'h0, stored_config_valid | (stored_config == config_q),
                trig_mode & ~config_q[`CFG_UART_STREAM_BIT] &
                (config_q[`CFG_BAUD_MSB:`CFG_BAUD_LSB] == 4'h0),
                acq_running, state_q == `ST_ARMED};
    else if (addr == `REG_EVENT_COUNT)
      rdata <= count_q;
    else
      rdata <= 8'h00;
  end
endmodule // external_trigger_unit
`default_nettype wire

// [bench/trig_props.sv]
// trig_props.sv: port assertions for the trigger unit
// assumes one clock and an asynchronous active-low reset
`default_nettype none
module trig_props
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic usb_only,
  input wire logic uart_path_en,
  input wire logic uart_rx_data,
  input wire logic uart_tx_pin,
  input wire logic acq_done,
  input wire logic acq_start,
  input wire logic acq_running,
  input wire logic stored_config_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // pin ownership follows the mode bit
  path_off_a: assert property (usb_only |-> !uart_path_en) else $error("uart path on");
  rx_held_a: assert property (usb_only |-> uart_rx_data) else $error("rx not held");
  // start pulse is launched by the same edge that enters the run state
  start_after_a: assert property ($rose(acq_running) |-> acq_start) else $error("no start");
  start_pulse_a: assert property (acq_start |=> !acq_start) else $error("long start");
  // output swings on entry and exit; a mode change hands tx back to the uart instead
  tx_on_a: assert property ($rose(acq_running) && usb_only |-> $changed(uart_tx_pin)) else $error("tx on");
  tx_off_a: assert property ($fell(acq_running) && usb_only && $past(usb_only) |-> $changed(uart_tx_pin))
    else $error("tx off");
  done_stop_a: assert property (acq_running && acq_done |=> !acq_running) else $error("run on");
  snap_pulse_a: assert property (stored_config_valid |=> !stored_config_valid) else $error("snap");
  cover property (acq_start);
  cover property ($fell(acq_running));
  cover property (stored_config_valid);
endmodule // trig_props
bind external_trigger_unit trig_props i_props (.*);
`default_nettype wire

// [bench/trig_partner.sv]
// trig_partner.sv: trigger source and receiver on the serial pins
// assumes the bench calls drive() just after a clock edge
`default_nettype none
module trig_partner
(
  input wire logic uart_tx_pin,
  output var logic uart_rx_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  int tx_swings = 0;
  // a uart line idles high
  initial uart_rx_pin = 1'b1;
  // edges land mid-cycle, unrelated to the probe clock
  task automatic drive(input logic v);
    #37 uart_rx_pin = v;
  endtask
  // tx is taken as a trigger flag only, never decoded as serial data
  always @(uart_tx_pin) tx_swings++;
endmodule // trig_partner
`default_nettype wire

// [bench/external_trigger_unit_test.sv]
// external_trigger_unit_test.sv: self-checking bench for the trigger unit
// assumes the partner drives the rx pin; 10 MHz clock
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: %h %h", $time, a, b); end end
module external_trigger_unit_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, rst_n, wr, rd, uart_tx_data, acq_done, uart_rx_pin, uart_tx_pin;
  logic       uart_rx_data, uart_path_en, usb_only, acq_start, acq_running, stored_config_valid;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, stored_config;
  int         err_count, compares, n;
  logic [9:0] rows [3] = '{10'h000, 10'h301, 10'h203}; // {usb, tx idle, config}
  external_trigger_unit i_dut (.*);
  trig_partner i_src (.*);
  // free-running clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // bus cycles start on an edge, so strobes never get two drives at once
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask
  // bounded wait on a start or snapshot pulse
  task automatic wait_hi(input bit snap);
    n = 0;
    #1;
    while (((snap ? stored_config_valid : acq_start) !== 1'b1) && n < 8)
    begin
      @(posedge clk);
      #1 n++;
    end
    if (n == 8)
    begin
      err_count++;
      test_done();
    end
  endtask
  task automatic test_done;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // main sequence
  initial
  begin
    {rst_n, wr, rd, uart_tx_data, acq_done} = '0;
    addr = 4'h0;
    wdata = 8'h00;
    repeat (20) @(posedge clk);
    `CHK({uart_tx_pin, uart_path_en, uart_rx_data, usb_only, rdata}, 12'hE00)
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      wr_reg(4'h0, rows[i][7:0]);
      rd_chk(4'h0, rows[i][7:0]);
      `CHK({usb_only, uart_path_en, uart_tx_pin}, {rows[i][9], ~rows[i][9], rows[i][8]})
      if (rows[i][9])
      begin
        // an edge before arming and the wrong edge after it are both ignored
        i_src.drive(rows[i][1]);
        // let the early edge clear the synchroniser before arming
        repeat (4) @(posedge clk);
        wr_reg(4'h4, 8'h01);
        i_src.drive(~rows[i][1]);
        repeat (6) @(posedge clk);
        `CHK(acq_running, 1'b0)
        i_src.drive(rows[i][1]);
        wait_hi(1'b0);
        `CHK(n >= 3 && n <= 5, 1'b1)
        `CHK({acq_running, uart_tx_pin}, {1'b1, rows[i][1]})
        @(posedge clk);
        acq_done <= 1'b1;
        @(posedge clk);
        acq_done <= 1'b0;
        #1 `CHK({acq_running, uart_tx_pin}, {1'b0, rows[i][8]})
      end
    end
    // software start, then a stop and a start in one write ending the run
    wr_reg(4'h4, 8'h02);
    wait_hi(1'b0);
    `CHK({acq_running, uart_tx_pin}, 2'b11)
    wr_reg(4'h4, 8'h06);
    repeat (2) @(posedge clk);
    `CHK({acq_running, uart_tx_pin}, 2'b00)
    wr_reg(4'h4, 8'h08);
    wait_hi(1'b1);
    `CHK(stored_config, 8'h03)
    rd_chk(4'h2, 8'h00);
    rd_chk(4'h8, 8'h0C);
    rd_chk(4'hC, 8'h03);
    test_done();
  end
endmodule // external_trigger_unit_test
`default_nettype wire
